// ==== src/dscm_top.sv ====
// serial host port, control register and monitor mux control of the dac
// assumes a 100 MHz ref_clk; the host link clock is oversampled
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "dscm_regs.svh"
module dscm_top #(
    parameter int unsigned POR_CYCLES = `DSCM_POR_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // serial host link
    input  wire logic        sclk,
    input  wire logic        sync_n,
    input  wire logic        sdin,
    output logic             sdout,
    output logic             sdout_oe,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // reference and monitor controls
    output logic             ref_internal,
    output logic             ref_2v5,
    output logic [5:0]       monitor_channel,
    output logic             monitor_route_en,
    output logic             monitor_output_oe,
    // calibration
    output logic             cal_load,
    output logic             cal_done
);
    import dscm_pkg::*;

    function automatic logic is_sfr(input dscm_word_t w, input logic [5:0] a);
        is_sfr = !w.rd && w.regsel == `DSCM_REGSEL_SFR && w.chan == a;
    endfunction

    function automatic logic [13:0] lane_merge(input logic [13:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        lane_merge = {sel[1] ? nw[13:8] : old[13:8],
                      sel[0] ? nw[7:0]  : old[7:0]};
    endfunction

    dscm_pins_t pins_in;
    dscm_pins_t pins_s;
    dscm_pins_t pins_rise;
    dscm_pins_t pins_fall;

    assign pins_in = '{sclk: sclk, sync_n: sync_n, sdin: sdin};

    dscm_sync_edge u_sync (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .pins_in   (pins_in),
        .pins_s    (pins_s),
        .pins_rise (pins_rise),
        .pins_fall (pins_fall)
    );

    // power-on reset and calibration load
    logic [19:0] por_cnt_q;
    logic        por_busy_q;
    logic        cal_load_q;
    logic        cal_done_q;
    logic        soft_rst;
    wire         por_end = por_busy_q && por_cnt_q == 20'(POR_CYCLES - 1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_q  <= 20'h0_0000;
            por_busy_q <= 1'b1;
            cal_load_q <= 1'b0;
            cal_done_q <= 1'b0;
        end else if (soft_rst) begin
            por_cnt_q  <= 20'h0_0000;
            por_busy_q <= 1'b1;
            cal_load_q <= 1'b0;
            cal_done_q <= 1'b0;
        end else begin
            por_cnt_q  <= por_busy_q ? por_cnt_q + 20'h0_0001 : por_cnt_q;
            por_busy_q <= por_busy_q && !por_end;
            cal_load_q <= por_end;
            cal_done_q <= cal_done_q || por_end;
        end
    end

    // frame tracking and shifting
    dscm_frame_t frame_q;
    dscm_frame_t frame_d;
    logic [`DSCM_CNT_W-1:0] bit_cnt_q;
    logic [23:0] rx_q;
    logic [23:0] tx_q;
    logic        sdout_q;
    logic        word_done_q;

    wire frame_start = pins_fall.sync_n;
    wire frame_stop  = pins_rise.sync_n;
    wire take_bit    = frame_q == DSCM_ST_SHIFT && pins_fall.sclk;
    wire send_bit    = frame_q == DSCM_ST_SHIFT && pins_rise.sclk;
    wire last_bit    = bit_cnt_q == 5'(`DSCM_WORD_BITS - 1);

    always_comb begin
        case (frame_q)
            DSCM_ST_IDLE:  frame_d = frame_start ? DSCM_ST_SHIFT : DSCM_ST_IDLE;
            DSCM_ST_SHIFT: frame_d = frame_stop ? DSCM_ST_IDLE :
                                     (take_bit && last_bit) ? DSCM_ST_FULL :
                                     DSCM_ST_SHIFT;
            DSCM_ST_FULL:  frame_d = frame_stop ? DSCM_ST_IDLE : DSCM_ST_FULL;
            default:       frame_d = DSCM_ST_IDLE;
        endcase
    end

    // readback source selected by the previous read request
    logic       rb_pend_q;
    logic [5:0] rb_addr_q;
    logic [13:0] ctrl_q;
    logic [5:0]  monsel_q;
    wire [13:0] rb_data = rb_addr_q == `DSCM_ADDR_MONSEL ?
                          {8'h00, monsel_q} : ctrl_q;

    // a new falling sync always restarts, even mid-word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q   <= DSCM_ST_IDLE;
            bit_cnt_q <= 5'h00;
            rx_q      <= 24'h00_0000;
            tx_q      <= 24'h00_0000;
            sdout_q   <= 1'b0;
        end else begin
            frame_q <= frame_d;
            if (frame_start) begin
                bit_cnt_q <= 5'h00;
                tx_q      <= rb_pend_q ? {rb_addr_q[5:0], 4'h0, rb_data} :
                             24'h00_0000;
            end else if (take_bit) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                rx_q      <= {rx_q[22:0], pins_s.sdin};
            end
            if (send_bit) begin
                sdout_q <= tx_q[23];
                tx_q    <= {tx_q[22:0], 1'b0};
            end
        end
    end

    // word completes only when the last bit lands inside the frame
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_done_q <= 1'b0;
        end else begin
            word_done_q <= take_bit && last_bit && !frame_stop;
        end
    end

    dscm_word_t rx_word;
    assign rx_word = rx_q;
    // words arriving during power-on reset are dropped: calibration pending
    wire act       = word_done_q && !por_busy_q;
    wire ser_ctrl  = act && is_sfr(rx_word, `DSCM_ADDR_CTRL);
    wire ser_mon   = act && is_sfr(rx_word, `DSCM_ADDR_MONSEL);
    wire ser_read  = act && rx_word.rd;

    // wishbone decode
    wire wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a write lands at the edge where the master sees ack high
    wire wb_wr     = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    wire wb_ctrl   = wb_wr && wb_adr_i == `DSCM_WB_CTRL;
    wire wb_mon    = wb_wr && wb_adr_i == `DSCM_WB_MONSEL;
    assign soft_rst = wb_wr && wb_adr_i == `DSCM_WB_SOFTRST && wb_sel_i[0]
                      && wb_dat_i[0];
    wire [31:0] status = {28'h000_0000, rb_pend_q, frame_q != DSCM_ST_IDLE,
                          cal_done_q, por_busy_q};
    wire [31:0] rd_mux = wb_adr_i == `DSCM_WB_CTRL   ? {18'h0_0000, ctrl_q} :
                         wb_adr_i == `DSCM_WB_MONSEL ? {26'h000_0000, monsel_q} :
                         wb_adr_i == `DSCM_WB_STATUS ? status : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
        end
    end

    // control and monitor registers; serial write wins over the bus
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= `DSCM_CTRL_RST;
            monsel_q  <= `DSCM_MONSEL_RST;
            rb_pend_q <= 1'b0;
            rb_addr_q <= 6'h00;
        end else if (soft_rst) begin
            ctrl_q    <= `DSCM_CTRL_RST;
            monsel_q  <= `DSCM_MONSEL_RST;
            rb_pend_q <= 1'b0;
        end else begin
            if (ser_ctrl)
                ctrl_q <= rx_word.data;
            else if (wb_ctrl)
                ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
            if (ser_mon)
                monsel_q <= rx_word.data[5:0];
            else if (wb_mon && wb_sel_i[0])
                monsel_q <= wb_dat_i[5:0];
            if (ser_read) begin
                rb_pend_q <= 1'b1;
                rb_addr_q <= rx_word.chan;
            end else if (frame_start) begin
                rb_pend_q <= 1'b0;
            end
        end
    end

    // registered pin and control outputs
    logic ref_int_q;
    logic ref_2v5_q;
    logic mon_route_q;
    logic mon_oe_q;
    logic sdout_oe_q;
    logic sdout_o_q;
    logic [5:0] mon_chan_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_int_q   <= 1'b0;
            ref_2v5_q   <= 1'b0;
            mon_route_q <= 1'b0;
            mon_oe_q    <= 1'b0;
            mon_chan_q  <= `DSCM_MONSEL_RST;
            sdout_oe_q  <= 1'b0;
            sdout_o_q   <= 1'b0;
        end else begin
            ref_int_q   <= ctrl_q[`DSCM_CR_REF_INT];
            ref_2v5_q   <= ctrl_q[`DSCM_CR_REF_VAL];
            mon_route_q <= ctrl_q[`DSCM_CR_MON_EN];
            mon_oe_q    <= ctrl_q[`DSCM_CR_MON_EN] &&
                           monsel_q != `DSCM_MON_TRISTATE;
            mon_chan_q  <= monsel_q;
            sdout_oe_q  <= frame_d != DSCM_ST_IDLE;
            sdout_o_q   <= sdout_q;
        end
    end

    assign ref_internal      = ref_int_q;
    assign ref_2v5           = ref_2v5_q;
    assign monitor_channel   = mon_chan_q;
    assign monitor_route_en  = mon_route_q;
    assign monitor_output_oe = mon_oe_q;
    assign sdout             = sdout_o_q;
    assign sdout_oe          = sdout_oe_q;
    assign cal_load          = cal_load_q;
    assign cal_done          = cal_done_q;
endmodule

// ==== src/dscm_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the serial config monitor design files only
`ifndef DSCM_REGS_SVH
`define DSCM_REGS_SVH

// serial word layout
`define DSCM_WORD_BITS      24
`define DSCM_CNT_W          5
`define DSCM_ADDR_CTRL      6'h0C
`define DSCM_ADDR_MONSEL    6'h0D
`define DSCM_REGSEL_SFR     2'h0
`define DSCM_MON_TRISTATE   6'h3F

// control register fields
`define DSCM_CTRL_W         14
`define DSCM_CTRL_RST       14'h0000
`define DSCM_CR_REF_VAL     12
`define DSCM_CR_REF_INT     10
`define DSCM_CR_MON_EN      9
`define DSCM_MONSEL_RST     6'h3F

// wishbone byte offsets
`define DSCM_WB_CTRL        4'h0
`define DSCM_WB_MONSEL      4'h4
`define DSCM_WB_STATUS      4'h8
`define DSCM_WB_SOFTRST     4'hC

// status fields
`define DSCM_ST_POR_BUSY    0
`define DSCM_ST_CAL_DONE    1
`define DSCM_ST_FRAME       2
`define DSCM_ST_RB_PEND     3

// power-on reset timing
`define DSCM_POR_MS         10
`define DSCM_CLK_KHZ        100000
`define DSCM_POR_CYCLES     (`DSCM_POR_MS * `DSCM_CLK_KHZ)

`endif

// ==== src/dscm_pkg.sv ====
// types shared by the serial config monitor design
// assumes dscm_regs.svh is on the include path
`include "dscm_regs.svh"

package dscm_pkg;

    typedef struct packed {
        logic       rd;
        logic       rsvd;
        logic [5:0] chan;
        logic [1:0] regsel;
        logic [13:0] data;
    } dscm_word_t;

    typedef enum logic [2:0] {
        DSCM_ST_IDLE  = 3'b001,
        DSCM_ST_SHIFT = 3'b010,
        DSCM_ST_FULL  = 3'b100
    } dscm_frame_t;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic sdin;
    } dscm_pins_t;

endpackage

// ==== src/dscm_sync_edge.sv ====
// two-flop synchroniser for the serial pins with edge detection
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
module dscm_sync_edge (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // raw pins and their synchronised view
    input  wire dscm_pkg::dscm_pins_t pins_in,
    output dscm_pkg::dscm_pins_t      pins_s,
    output dscm_pkg::dscm_pins_t      pins_rise,
    output dscm_pkg::dscm_pins_t      pins_fall
);
    import dscm_pkg::*;

    dscm_pins_t meta_q;
    dscm_pins_t sync_q;
    dscm_pins_t prev_q;

    // frame sync idles high, so it resets high to avoid a false start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 3'b010;
            sync_q <= 3'b010;
            prev_q <= 3'b010;
        end else begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign pins_s    = sync_q;
    assign pins_rise = sync_q & ~prev_q;
    assign pins_fall = ~sync_q & prev_q;
endmodule

// ==== testbench/dscm_top_sva.sv ====
// concurrent checks on the serial config monitor top ports
// assumes one ref_clk domain and the async active-low rst_n
`timescale 1ns/1ps
module dscm_top_sva #(
    parameter int unsigned POR_CYCLES = 20
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // serial link
    input wire logic        sync_n,
    input wire logic        sdout_oe,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // controls
    input wire logic        ref_internal,
    input wire logic [5:0]  monitor_channel,
    input wire logic        monitor_route_en,
    input wire logic        monitor_output_oe,
    input wire logic        cal_load,
    input wire logic        cal_done
);
    logic [31:0] cnt_q;

    // saturates so a long run never wraps back into the early window
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= 32'h0000_0000;
        else if (cnt_q != 32'hFFFF_FFFF) cnt_q <= cnt_q + 32'h0000_0001;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_ack_next: assert property (s_req |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero while idle");
    a_reset_defaults: assert property ($rose(rst_n) |->
        !ref_internal && !monitor_route_en && monitor_channel == 6'h3F)
        else $error("wrong state after reset");
    a_cal_early: assert property (cnt_q < POR_CYCLES / 2 |-> !cal_load)
        else $error("calibration load too early");
    a_cal_pulse: assert property (cal_load |=> !cal_load && cal_done)
        else $error("calibration pulse or done wrong");
    a_mon_gate: assert property ((!monitor_route_en) [*2]
        |-> !monitor_output_oe)
        else $error("monitor driven while disabled");
    a_mon_float: assert property ((monitor_channel == 6'h3F) [*2]
        |-> !monitor_output_oe)
        else $error("monitor driven at address 63");
    a_idle_sync: assert property (sync_n [*5] |-> !sdout_oe)
        else $error("readback driven outside frame");
endmodule

bind dscm_top dscm_top_sva #(.POR_CYCLES(POR_CYCLES)) u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .sync_n(sync_n),
    .sdout_oe(sdout_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ref_internal(ref_internal), .monitor_channel(monitor_channel),
    .monitor_route_en(monitor_route_en),
    .monitor_output_oe(monitor_output_oe),
    .cal_load(cal_load), .cal_done(cal_done));

// ==== testbench/dscm_host_model.sv ====
// behavioural serial host master facing the device link
// assumes a 160 ns link clock, idle low, stopped between frames
`timescale 1ns/1ps
module dscm_host_model (
    // link toward the device
    output logic sclk,
    output logic sync_n,
    output logic sdin,
    // readback from the device
    input  wire logic sdout
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdin = 1'b0;
    end

    // n below 24 closes the frame early; bytes pauses after each byte
    task automatic xfer(input logic [23:0] w, input int n,
                        input bit bytes, output logic [23:0] rb);
        rb = 24'h00_0000;
        sync_n = 1'b0;
        #80;
        for (int i = 23; i > 23 - n; i--) begin
            sdin = w[i];
            #40 sclk = 1'b1;
            #80 sclk = 1'b0;
            rb = {rb[22:0], sdout};
            #40;
            if (bytes && i % 8 == 0) #400;
        end
        sync_n = 1'b1;
        // released line must not keep its last value
        sdin = ~sdin;
        #320;
    endtask
endmodule

// ==== testbench/dscm_top_test.sv ====
// self-checking bench for the serial config monitor top
// assumes the host model drives the link, bench drives wishbone
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %0t: got %h exp %h", $time, g, e); \
    end end
module dscm_top_test;
    typedef struct packed {
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic [3:0]  outs;
    } dscm_row_t;

    localparam int unsigned POR = 20;
    logic        ref_clk, rst_n, sclk, sync_n, sdin, sdout, sdout_oe;
    logic        wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0]  wb_adr, wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic        ref_int, ref_2v5, mon_en, mon_oe, cal_load, cal_done;
    logic [5:0]  mon_ch;
    logic [23:0] rb;
    int          miscompares = 0;
    int          tests_run = 0;
    // outs: ref_2v5, ref_int, mon_en, mon_oe
    dscm_row_t   rows [10] = '{
        '{1'b1, 4'h0, 4'hF, 32'h0000_1600, 4'b1110},
        '{1'b0, 4'h0, 4'hF, 32'h0000_1600, 4'b1110},
        '{1'b1, 4'h4, 4'hF, 32'h0000_0005, 4'b1111},
        '{1'b0, 4'h4, 4'hF, 32'h0000_0005, 4'b1111},
        '{1'b1, 4'h0, 4'h2, 32'h0000_0400, 4'b0100},
        '{1'b1, 4'h0, 4'hF, 32'h0000_0200, 4'b0011},
        '{1'b1, 4'h4, 4'hF, 32'h0000_003F, 4'b0010},
        '{1'b1, 4'h3, 4'hF, 32'h0000_FFFF, 4'b0010},
        '{1'b0, 4'h3, 4'hF, 32'h0000_0000, 4'b0010},
        '{1'b0, 4'h8, 4'hF, 32'h0000_0002, 4'b0010}};

    dscm_top #(.POR_CYCLES(POR)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n),
        .sdin(sdin), .sdout(sdout), .sdout_oe(sdout_oe),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ref_internal(ref_int),
        .ref_2v5(ref_2v5), .monitor_channel(mon_ch),
        .monitor_route_en(mon_en), .monitor_output_oe(mon_oe),
        .cal_load(cal_load), .cal_done(cal_done));

    dscm_host_model u_host (
        .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdout(sdout));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // entered just after a rising edge; waits for ack with no bound of its own
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [3:0] sel, input logic [31:0] dat);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_wdat <= dat;
        do begin
            @(posedge ref_clk);
        end while (wb_ack !== 1'b1);
        `CHK(wb_ack, 1'b1)
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask

    initial begin
        #200000;
        miscompares++;
        end_sim;
    end

    initial begin
        {rst_n, wb_cyc, wb_stb, wb_we} = 4'h0;
        {wb_adr, wb_sel, wb_wdat} = 40'h00_0000_0000;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({ref_int, mon_ch, cal_done}, {1'b0, 6'h3F, 1'b0})
        repeat (30) @(posedge ref_clk);
        `CHK(cal_done, 1'b1)
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
            if (!rows[i].we) `CHK(rd, rows[i].dat)
            repeat (2) @(posedge ref_clk);
            `CHK({ref_2v5, ref_int, mon_en, mon_oe}, rows[i].outs)
        end
        u_host.xfer({2'b00, 6'h0C, 2'b00, 14'h1400}, 24, 1'b1, rb);
        `CHK({ref_2v5, ref_int, mon_en}, 3'b110)
        u_host.xfer({2'b00, 6'h0D, 2'b00, 14'h0007}, 20, 1'b0, rb);
        `CHK(mon_ch, 6'h3F)
        u_host.xfer({2'b00, 6'h0D, 2'b00, 14'h0007}, 24, 1'b0, rb);
        `CHK(mon_ch, 6'h07)
        u_host.xfer({2'b10, 6'h0C, 16'h0000}, 24, 1'b0, rb);
        u_host.xfer(24'h00_0000, 24, 1'b0, rb);
        `CHK(rb, {6'h0C, 4'h0, 14'h1400})
        @(posedge ref_clk);
        wb(1'b1, 4'hC, 4'hF, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        `CHK({ref_int, mon_ch, cal_done}, {1'b0, 6'h3F, 1'b0})
        repeat (40) @(posedge ref_clk);
        `CHK(cal_done, 1'b1)
        end_sim;
    end
endmodule
